// File: src/sfp_params.svh
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH

// Serial framing.
`define SFP_CMD_BITS 5'h08
`define SFP_ADDR_BITS 5'h18
`define SFP_BYTE_BITS 5'h08

// Array geometry: 512 KB behind a 19-bit byte address.
`define SFP_ARRAY_ABITS 19
`define SFP_PAGE_BYTES 256
`define SFP_PAGES 2048
`define SFP_SECTORS 128
`define SFP_BLK32_COUNT 16
`define SFP_BLK64_COUNT 8

// Continuous read overhead in serial clocks (24 address bits plus mode byte, two lanes).
`define SFP_CONT_OVERHEAD 16

// Unique serial number; the value is arbitrary.
`define SFP_UID_VALUE 64'h5A3C_96E1_0F87_2DB4

// System clock period.
`define SFP_MCLK_NS 40

`endif

// File: src/sfp_pkg.sv
package sfp_pkg;

    // Frame phases of the serial front end.
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_CMD,
        PH_DECODE,
        PH_ADDR,
        PH_EXTRA,
        PH_DATA
    } sfp_phase_t;

endpackage : sfp_pkg

// File: src/sfp_sync.sv
`timescale 1ns/1ps

module sfp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstN,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    // Two flops per bit; the first stage is read only by the second.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            logic meta_q;
            always_ff @(posedge mclk or negedge rstN) begin
                if (!rstN) begin
                    meta_q <= RST_VAL[i];
                    syncOut[i] <= RST_VAL[i];
                end else begin
                    meta_q <= asyncIn[i];
                    syncOut[i] <= meta_q;
                end
            end
        end
    endgenerate

endmodule : sfp_sync

// File: src/sfp_guard.sv
`timescale 1ns/1ps
`include "sfp_params.svh"

module sfp_guard (
    // Address under test
    input wire logic [`SFP_ARRAY_ABITS-1:0] byteAddr,
    // Protection controls
    input wire logic [2:0] regionGuardBits,
    input wire logic guardFromLowEnd,
    input wire logic statusLockBit,
    input wire logic writeGuardN,
    // Results
    output logic statusWriteBlocked,
    output logic addrProtected,
    output logic [10:0] pageIdx,
    output logic [6:0] sectorIdx,
    output logic [3:0] blk32Idx,
    output logic [2:0] blk64Idx
);

    // Geometry: 256-byte pages, 4 KB sectors, 32 KB and 64 KB blocks.
    assign pageIdx = byteAddr[18:8];
    assign sectorIdx = byteAddr[18:12];
    assign blk32Idx = byteAddr[18:15];
    assign blk64Idx = byteAddr[18:16];

    // Status writes are refused while the lock bit is set and the guard pin is low.
    assign statusWriteBlocked = statusLockBit & ~writeGuardN;

    // Guarded span in 64 KB blocks doubles per code step; codes 4 and up cover the array.
    wire logic [3:0] spanBlocks;
    wire logic [3:0] blkWide;
    wire logic inLow;
    wire logic inHigh;
    assign spanBlocks = (regionGuardBits == 3'h0) ? 4'h0 :
                        (regionGuardBits >= 3'h4) ? 4'h8 :
                        4'(4'h1 << (regionGuardBits - 3'h1));
    assign blkWide = {1'b0, blk64Idx};
    assign inLow = blkWide < spanBlocks;
    assign inHigh = blkWide >= 4'(4'h8 - spanBlocks);
    assign addrProtected = guardFromLowEnd ? inLow : inHigh;

endmodule : sfp_guard

// File: src/sfp_port.sv
`timescale 1ns/1ps
`include "sfp_params.svh"

// Summary of operation
// - Single mode samples lane0 on rising clock.
// - Single mode drives lane1 on falling clock.
// - Dual mode moves two bits per clock.
// - Chip select high floats both lanes.
// - No command before first select falling edge.
// - Pause floats outputs, ignores clock and data.
// - Released pause resumes from preserved state.
// - Low guard pin can block status writes.
// - Guard bits protect part of the array.
// - Array holds 2048 pages of 256 bytes.
// - Program writes wrap inside one page.
// - Erase units: 4KB sectors, 32KB, 64KB blocks.
// - Continuous read starts directly with address.
// - A 64-bit unique number is readable.
// - Modes 0 and 3; clock idle at select.
// - Pause begins and ends with clock low.
module sfp_port (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Serial pins
    input wire logic sclkPin,
    input wire logic chipSelPin_b,
    input wire logic pausePin_b,
    input wire logic writeGuardPin_b,
    input wire logic serialInLane0In,
    output logic serialInLane0Out,
    output logic serialInLane0Oe,
    input wire logic serialOutLane1In,
    output logic serialOutLane1Out,
    output logic serialOutLane1Oe,
    // Command layer: decode answers, valid in the cycle that cmdValid is high
    output logic cmdValid,
    output logic [7:0] cmdByte,
    input wire logic addrFollows,
    input wire logic extraFollows,
    input wire logic readDir,
    input wire logic dualIo,
    input wire logic dualData,
    input wire logic uidSel,
    input wire logic contRead,
    // Data stream
    input wire logic [7:0] rdData,
    output logic rdReq,
    output logic [23:0] xferAddr,
    output logic wrValid,
    output logic [7:0] wrData,
    output logic [23:0] wrAddr,
    output logic extraValid,
    output logic [7:0] extraByte,
    output logic paused,
    // Protection
    input wire logic statusLockBit,
    input wire logic [2:0] regionGuardBits,
    input wire logic guardFromLowEnd,
    output logic statusWriteBlocked,
    output logic addrProtected,
    output logic [10:0] pageIdx,
    output logic [6:0] sectorIdx,
    output logic [3:0] blk32Idx,
    output logic [2:0] blk64Idx
);

    // Reset release through two flops; assertion stays asynchronous.
    logic rstMeta_q;
    logic rstN;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_q <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstN <= rstMeta_q;
        end
    end

    // All pins cross into mclk; the serial clock is sampled, so it must stay below mclk/4.
    logic sclkS;
    logic csS_b;
    logic pauseS_b;
    logic guardS_b;
    logic in0S;
    logic in1S;
    sfp_sync #(.WIDTH(6), .RST_VAL(6'h1C)) u_sync (
        .mclk(mclk),
        .rstN(rstN),
        .asyncIn({chipSelPin_b, pausePin_b, writeGuardPin_b, sclkPin, serialOutLane1In,
                  serialInLane0In}),
        .syncOut({csS_b, pauseS_b, guardS_b, sclkS, in1S, in0S})
    );

    // Frame state.
    sfp_pkg::sfp_phase_t phase_q;
    logic csPrev_q;
    logic active_q;
    logic pause_q;
    logic sclkPrev_q;
    logic [4:0] cnt_q;
    logic [23:0] shIn_q;
    logic [23:0] addr_q;
    logic [7:0] pageOfs_q;
    logic wide_q;
    logic dualIo_q;
    logic dualData_q;
    logic readDir_q;
    logic extra_q;
    logic uidSel_q;
    logic [7:0] outSh_q;
    logic [3:0] outCnt_q;
    logic [2:0] uidIdx_q;

    // Edge detection; a prior reset value of 0 means power-up needs a high-to-low select.
    wire logic csFall;
    wire logic rise;
    wire logic fall;
    assign csFall = csPrev_q & ~csS_b;
    assign rise = active_q & ~csS_b & ~pause_q & sclkS & ~sclkPrev_q;
    assign fall = active_q & ~csS_b & ~pause_q & ~sclkS & sclkPrev_q;

    // Lane width, incoming shift and the count after this edge, MSB first.
    wire logic [4:0] step;
    wire logic [4:0] cntNext;
    wire logic [23:0] shNext;
    assign step = wide_q ? 5'h02 : 5'h01;
    assign cntNext = 5'(cnt_q + step);
    assign shNext = wide_q ? {shIn_q[21:0], in1S, in0S} : {shIn_q[22:0], in0S};

    // Outgoing byte source and next output bits.
    wire logic [63:0] uidWord;
    wire logic [5:0] uidBase;
    wire logic [7:0] srcByte;
    wire logic needLoad;
    wire logic [7:0] outWord;
    wire logic [3:0] outStep;
    wire logic [3:0] outLeft;
    wire logic driveNow;
    assign uidWord = `SFP_UID_VALUE;
    assign uidBase = {~uidIdx_q, 3'h0};
    assign srcByte = uidSel_q ? uidWord[uidBase +: 8] : rdData;
    assign needLoad = (outCnt_q == 4'h0);
    assign outWord = needLoad ? srcByte : outSh_q;
    assign outStep = wide_q ? 4'h2 : 4'h1;
    assign outLeft = needLoad ? 4'(4'h8 - outStep) : 4'(outCnt_q - outStep);
    assign driveNow = active_q & ~csS_b & ~pause_q & (phase_q == sfp_pkg::PH_DATA) & readDir_q;

    // Pause: entered or left by the pin only while the serial clock is low; deselect ends it at any time.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            pause_q <= 1'b0;
        end else if (csS_b) begin
            pause_q <= 1'b0;
        end else if (!sclkS) begin
            pause_q <= ~pauseS_b;
        end
    end

    // Select tracking; the clock history freezes during a pause so no edge is seen.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            csPrev_q <= 1'b0;
            active_q <= 1'b0;
            sclkPrev_q <= 1'b0;
        end else begin
            csPrev_q <= csS_b;
            active_q <= csS_b ? 1'b0 : (active_q | csFall);
            if (csS_b || !pause_q) begin
                sclkPrev_q <= sclkS;
            end
        end
    end

    // Frame sequencer: command, decode, address, extra byte, data.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            phase_q <= sfp_pkg::PH_IDLE;
            cnt_q <= 5'h00;
            shIn_q <= 24'h000000;
            addr_q <= 24'h000000;
            pageOfs_q <= 8'h00;
            wide_q <= 1'b0;
            dualIo_q <= 1'b0;
            dualData_q <= 1'b0;
            readDir_q <= 1'b0;
            extra_q <= 1'b0;
            uidSel_q <= 1'b0;
            cmdValid <= 1'b0;
            cmdByte <= 8'h00;
            extraValid <= 1'b0;
            extraByte <= 8'h00;
            wrValid <= 1'b0;
            wrData <= 8'h00;
            wrAddr <= 24'h000000;
            rdReq <= 1'b0;
            outSh_q <= 8'h00;
            outCnt_q <= 4'h0;
            uidIdx_q <= 3'h0;
            serialOutLane1Out <= 1'b0;
            serialInLane0Out <= 1'b0;
        end else begin
            cmdValid <= 1'b0;
            extraValid <= 1'b0;
            wrValid <= 1'b0;
            rdReq <= 1'b0;
            if (csS_b) begin
                phase_q <= sfp_pkg::PH_IDLE;
                wide_q <= 1'b0;
            end else if (csFall) begin
                cnt_q <= 5'h00;
                outCnt_q <= 4'h0;
                uidIdx_q <= 3'h0;
                pageOfs_q <= 8'h00;
                // Continuous read skips the command byte and goes straight to the address.
                phase_q <= contRead ? sfp_pkg::PH_ADDR : sfp_pkg::PH_CMD;
                wide_q <= contRead & dualIo;
                dualIo_q <= dualIo;
                dualData_q <= dualData;
                readDir_q <= contRead;
                extra_q <= contRead & extraFollows;
                uidSel_q <= 1'b0;
            end else begin
                case (phase_q)
                    sfp_pkg::PH_CMD: begin
                        if (rise) begin
                            shIn_q <= shNext;
                            cnt_q <= cntNext;
                            if (cntNext == `SFP_CMD_BITS) begin
                                cmdByte <= shNext[7:0];
                                cmdValid <= 1'b1;
                                phase_q <= sfp_pkg::PH_DECODE;
                            end
                        end
                    end
                    sfp_pkg::PH_DECODE: begin
                        cnt_q <= 5'h00;
                        dualIo_q <= dualIo;
                        dualData_q <= dualData;
                        readDir_q <= readDir;
                        extra_q <= extraFollows;
                        uidSel_q <= uidSel;
                        wide_q <= dualIo | (dualData & ~addrFollows & ~extraFollows);
                        if (addrFollows) begin
                            phase_q <= sfp_pkg::PH_ADDR;
                        end else if (extraFollows) begin
                            phase_q <= sfp_pkg::PH_EXTRA;
                        end else begin
                            phase_q <= sfp_pkg::PH_DATA;
                            rdReq <= readDir;
                        end
                    end
                    sfp_pkg::PH_ADDR: begin
                        if (rise) begin
                            shIn_q <= shNext;
                            cnt_q <= cntNext;
                            if (cntNext == `SFP_ADDR_BITS) begin
                                addr_q <= shNext;
                                pageOfs_q <= shNext[7:0];
                                cnt_q <= 5'h00;
                                if (extra_q) begin
                                    phase_q <= sfp_pkg::PH_EXTRA;
                                end else begin
                                    phase_q <= sfp_pkg::PH_DATA;
                                    wide_q <= dualIo_q | dualData_q;
                                    rdReq <= readDir_q;
                                end
                            end
                        end
                    end
                    sfp_pkg::PH_EXTRA: begin
                        if (rise) begin
                            shIn_q <= shNext;
                            cnt_q <= cntNext;
                            if (cntNext == `SFP_BYTE_BITS) begin
                                extraByte <= shNext[7:0];
                                extraValid <= 1'b1;
                                cnt_q <= 5'h00;
                                phase_q <= sfp_pkg::PH_DATA;
                                wide_q <= dualIo_q | dualData_q;
                                rdReq <= readDir_q;
                            end
                        end
                    end
                    sfp_pkg::PH_DATA: begin
                        if (rise && !readDir_q) begin
                            shIn_q <= shNext;
                            cnt_q <= cntNext;
                            if (cntNext == `SFP_BYTE_BITS) begin
                                cnt_q <= 5'h00;
                                wrData <= shNext[7:0];
                                wrValid <= 1'b1;
                                // A program burst stays inside its page and wraps.
                                wrAddr <= {addr_q[23:8], pageOfs_q};
                                pageOfs_q <= 8'(pageOfs_q + 8'h01);
                            end
                        end
                        if (fall && readDir_q) begin
                            // Lane 1 carries the higher bit of each pair.
                            serialOutLane1Out <= outWord[7];
                            serialInLane0Out <= outWord[6];
                            outSh_q <= wide_q ? {outWord[5:0], 2'h0} : {outWord[6:0], 1'h0};
                            outCnt_q <= outLeft;
                            if (needLoad) begin
                                uidIdx_q <= 3'(uidIdx_q + 3'h1);
                            end
                            if (outLeft == 4'h0) begin
                                addr_q <= 24'(addr_q + 24'h000001);
                                rdReq <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        phase_q <= sfp_pkg::PH_IDLE;
                    end
                endcase
            end
        end
    end

    // Lane enables; deselect or pause float both lanes from the next cycle.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            serialOutLane1Oe <= 1'b0;
            serialInLane0Oe <= 1'b0;
            paused <= 1'b0;
        end else begin
            serialOutLane1Oe <= driveNow;
            serialInLane0Oe <= driveNow & wide_q;
            paused <= pause_q;
        end
    end

    // Protection and geometry from the current transfer address.
    wire logic guardBlock;
    wire logic guardProt;
    wire logic [10:0] pageW;
    wire logic [6:0] sectorW;
    wire logic [3:0] blk32W;
    wire logic [2:0] blk64W;
    sfp_guard u_guard (
        .byteAddr(addr_q[`SFP_ARRAY_ABITS-1:0]),
        .regionGuardBits(regionGuardBits),
        .guardFromLowEnd(guardFromLowEnd),
        .statusLockBit(statusLockBit),
        .writeGuardN(guardS_b),
        .statusWriteBlocked(guardBlock),
        .addrProtected(guardProt),
        .pageIdx(pageW),
        .sectorIdx(sectorW),
        .blk32Idx(blk32W),
        .blk64Idx(blk64W)
    );

    // Registered copies so every result leaves from a flop.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            statusWriteBlocked <= 1'b0;
            addrProtected <= 1'b0;
            pageIdx <= 11'h000;
            sectorIdx <= 7'h00;
            blk32Idx <= 4'h0;
            blk64Idx <= 3'h0;
            xferAddr <= 24'h000000;
        end else begin
            statusWriteBlocked <= guardBlock;
            addrProtected <= guardProt;
            pageIdx <= pageW;
            sectorIdx <= sectorW;
            blk32Idx <= blk32W;
            blk64Idx <= blk64W;
            xferAddr <= addr_q;
        end
    end

    AST_DESEL_FLOAT: assert property (@(posedge mclk) disable iff (!rstN)
        csS_b |=> !serialOutLane1Oe && !serialInLane0Oe) else $error("lane driven while deselected");
    AST_PAUSE_FLOAT: assert property (@(posedge mclk) disable iff (!rstN)
        pause_q |=> !serialOutLane1Oe && !serialInLane0Oe) else $error("lane driven in pause");
    AST_CMD_NEEDS_SELECT: assert property (@(posedge mclk) disable iff (!rstN)
        $rose(cmdValid) |-> $past(active_q)) else $error("command without select edge");
    AST_CMD_EIGHT: assert property (@(posedge mclk) disable iff (!rstN)
        $rose(cmdValid) |-> $past(cnt_q) == 5'h07 && $past(rise)) else $error("command length");
    AST_OUT_ON_FALL: assert property (@(posedge mclk) disable iff (!rstN)
        !fall |=> $stable(serialOutLane1Out)) else $error("lane1 moved without falling clock");
    AST_PAUSE_KEEPS: assert property (@(posedge mclk) disable iff (!rstN)
        pause_q && !csS_b |=> $stable(phase_q) && $stable(cnt_q)) else $error("state lost in pause");
    AST_PAUSE_START: assert property (@(posedge mclk) disable iff (!rstN)
        !csS_b && !pauseS_b && !sclkS |=> pause_q) else $error("pause not entered");
    AST_WRITE_GUARD: assert property (@(posedge mclk) disable iff (!rstN)
        statusLockBit && !guardS_b |=> statusWriteBlocked) else $error("status write not blocked");
    AST_DUAL_STEP: assert property (@(posedge mclk) disable iff (!rstN)
        rise && wide_q && phase_q == sfp_pkg::PH_ADDR && !csFall
        |=> cnt_q == 5'($past(cnt_q) + 5'h02) || cnt_q == 5'h00) else $error("dual step");
    AST_CONT_ADDR: assert property (@(posedge mclk) disable iff (!rstN)
        csFall && contRead |=> phase_q == sfp_pkg::PH_ADDR) else $error("continuous read");

endmodule : sfp_port

// File: dv/sfp_host_model.sv
`timescale 1ns/1ps

// Bus master on the serial link in mode 0: the clock idles low outside frames.
module sfp_host_model (
    // System clock used to pace the link
    input wire logic mclk,
    // Link pins
    output logic sclk,
    output logic csB,
    output logic pauseB,
    output logic d0,
    input wire logic q0,
    input wire logic q1
);
    // Select starts low so the power-up gate is exercised.
    initial begin
        sclk = 1'h0;
        csB = 1'h0;
        pauseB = 1'h1;
        d0 = 1'h0;
    end

    // Six system cycles a half period keep the link well under a quarter of mclk.
    task automatic hw();
        repeat (6) @(negedge mclk);
    endtask : hw

    // Data changes while the clock is low and is sampled at the rise.
    task automatic bitClk(input logic v, output logic s1, output logic s0);
        d0 = v;
        hw();
        sclk = 1'h1;
        s1 = q1;
        s0 = q0;
        hw();
        sclk = 1'h0;
    endtask : bitClk

    // One byte, high bit first; in dual reads d0 toggles as junk while the device drives lane0.
    task automatic xfer(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
        logic s1;
        logic s0;
        rx = 8'h00;
        for (int i = 0; i < (dual ? 4 : 8); i++) begin
            bitClk(dual ? ~d0 : tx[7-i], s1, s0);
            rx = dual ? {rx[5:0], s1, s0} : {rx[6:0], s1};
        end
    endtask : xfer

    // Select edges are made with the clock at its idle level.
    task automatic frame(input logic sel);
        csB = ~sel;
        hw();
        hw();
    endtask : frame

    // Pause edges fall with the clock low; select stays low throughout.
    task automatic pauseSet(input logic v);
        pauseB = v;
        hw();
    endtask : pauseSet
endmodule : sfp_host_model

// File: dv/serial_flash_spi_port_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module serial_flash_spi_port_tb;
    logic mclk = 1'h0;
    logic rst_b = 1'h0;
    logic writeGuardPin_b = 1'h1;
    logic addrFollows = 1'h0, readDir = 1'h0, dualData = 1'h0, contRead = 1'h0;
    logic lockBit = 1'h0;
    logic lowEnd = 1'h0, uidSel = 1'h0, dualIo = 1'h0, extraFollows = 1'h0;
    logic [2:0] guardBits = 3'h0;
    logic [7:0] rdData = 8'h00;
    logic [31:0] lfsr = 32'h00010F28;
    int error_cnt = 0;
    int num_checks = 0;
    logic [7:0] cmdQ[$];
    logic [7:0] rdQ[$];
    logic [31:0] wrQ[$];
    wire logic sclk, csB, pauseB, hD0, l0Out, l0Oe, l1Out, l1Oe, cmdValid, rdReq, wrValid;
    wire logic paused, swBlk, prot;
    wire logic [7:0] cmdByte, wrData;
    wire logic [23:0] xferAddr, wrAddr;
    wire logic [10:0] pageIdx;
    wire logic [6:0] sectorIdx;
    wire logic [2:0] blk64Idx;
    // Released lines show a pattern that changes, never a held last value.
    wire logic lane0 = l0Oe ? l0Out : hD0;
    wire logic lane1 = l1Oe ? l1Out : (hD0 ^ sclk);

    // Free-running 25 MHz clock.
    initial forever #20 mclk = ~mclk;

    function automatic logic [31:0] nextRnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nextRnd

    sfp_host_model u_host (.mclk(mclk), .sclk(sclk), .csB(csB), .pauseB(pauseB), .d0(hD0),
        .q0(lane0), .q1(lane1));

    sfp_port u_dut (.mclk(mclk), .rst_b(rst_b), .sclkPin(sclk), .chipSelPin_b(csB),
        .pausePin_b(pauseB), .writeGuardPin_b(writeGuardPin_b), .serialInLane0In(lane0),
        .serialInLane0Out(l0Out), .serialInLane0Oe(l0Oe), .serialOutLane1In(lane1),
        .serialOutLane1Out(l1Out), .serialOutLane1Oe(l1Oe), .cmdValid(cmdValid),
        .cmdByte(cmdByte), .addrFollows(addrFollows), .extraFollows(extraFollows),
        .readDir(readDir), .dualIo(dualIo), .dualData(dualData), .uidSel(uidSel),
        .contRead(contRead),
        .rdData(rdData), .rdReq(rdReq), .xferAddr(xferAddr), .wrValid(wrValid),
        .wrData(wrData), .wrAddr(wrAddr), .extraValid(), .extraByte(), .paused(paused),
        .statusLockBit(lockBit), .regionGuardBits(guardBits), .guardFromLowEnd(lowEnd),
        .statusWriteBlocked(swBlk), .addrProtected(prot), .pageIdx(pageIdx),
        .sectorIdx(sectorIdx), .blk32Idx(), .blk64Idx(blk64Idx));

    // Each result pulse takes the oldest note; a pulse with no note fails on purpose.
    always @(negedge mclk) begin
        logic [7:0] e8;
        logic [31:0] e32;
        if (cmdValid) begin
            e8 = (cmdQ.size() != 0) ? cmdQ.pop_front() : ~cmdByte;
            `CHK("cmdByte", e8, cmdByte)
        end
        if (wrValid) begin
            e32 = (wrQ.size() != 0) ? wrQ.pop_front() : ~{wrAddr, wrData};
            `CHK("write", e32, {wrAddr, wrData})
        end
    end

    // A fresh random byte per read request, noted for the host side.
    always @(negedge mclk) begin
        if (rdReq) begin
            lfsr = nextRnd(lfsr);
            rdData = lfsr[7:0];
            rdQ.push_back(lfsr[7:0]);
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    // Command (unless continuous), three address bytes, then n data bytes.
    task automatic doRead(input logic cont, input logic dual, input logic [23:0] a, input int n);
        logic [7:0] rx;
        logic [7:0] e8;
        addrFollows = 1'h1;
        readDir = 1'h1;
        dualData = dual;
        contRead = cont;
        u_host.frame(1'h1);
        if (!cont) begin
            cmdQ.push_back(8'h3B);
            u_host.xfer(8'h3B, 1'h0, rx);
        end
        for (int i = 2; i >= 0; i--) u_host.xfer(a[8*i +: 8], 1'h0, rx);
        `CHK("xferAddr", a, xferAddr)
        `CHK("pageIdx", a[18:8], pageIdx)
        `CHK("sectorIdx", a[18:12], sectorIdx)
        `CHK("blk64Idx", a[18:16], blk64Idx)
        `CHK("addrProtected", guardBits != 3'h0, prot)
        repeat (n) begin
            u_host.xfer(8'h00, dual, rx);
            e8 = rdQ.pop_front();
            `CHK("readByte", e8, rx)
        end
        u_host.frame(1'h0);
        `CHK("laneOe", 2'h0, {l0Oe, l1Oe})
        rdQ.delete();
        contRead = 1'h0;
    endtask : doRead

    // Main sequence; the watchdog below shares the same ending.
    initial begin
        logic [7:0] rx;
        logic [7:0] d;
        logic s1;
        logic s0;
        repeat (12) @(negedge mclk);
        rst_b = 1'h1;
        repeat (6) @(negedge mclk);
        u_host.xfer(8'hA5, 1'h0, rx);
        u_host.frame(1'h0);
        $display("test select_gate done");
        guardBits = 3'h7;
        // Either end gives full cover at code 7 and none at code 0.
        lfsr = nextRnd(lfsr);
        lowEnd = lfsr[0];
        doRead(1'h0, 1'h0, 24'h012345, 2);
        guardBits = 3'h0;
        doRead(1'h0, 1'h1, 24'h07FFFE, 2);
        doRead(1'h1, 1'h0, 24'h000100, 1);
        $display("test reads done");
        readDir = 1'h0;
        // The number source only matters for reads, so a random choice is harmless here.
        uidSel = lfsr[1];
        u_host.frame(1'h1);
        cmdQ.push_back(8'h02);
        u_host.xfer(8'h02, 1'h0, rx);
        for (int i = 2; i >= 0; i--) u_host.xfer(8'hFF >> (8 * i), 1'h0, rx);
        for (int i = 0; i < 2; i++) begin
            lfsr = nextRnd(lfsr);
            d = lfsr[7:0];
            wrQ.push_back({16'h0000, 8'hFF + i[7:0], d});
            u_host.xfer(d, 1'h0, rx);
        end
        u_host.frame(1'h0);
        $display("test page_wrap done");
        addrFollows = 1'h0;
        u_host.frame(1'h1);
        cmdQ.push_back(8'h9F);
        d = 8'h9F;
        for (int i = 7; i >= 4; i--) u_host.bitClk(d[i], s1, s0);
        u_host.pauseSet(1'h0);
        `CHK("paused", 1'h1, paused)
        `CHK("laneOe", 2'h0, {l0Oe, l1Oe})
        repeat (3) u_host.bitClk(1'h0, s1, s0);
        u_host.pauseSet(1'h1);
        for (int i = 3; i >= 0; i--) u_host.bitClk(d[i], s1, s0);
        u_host.frame(1'h0);
        $display("test pause done");
        for (int i = 0; i < 4; i++) begin
            lockBit = i[0];
            writeGuardPin_b = i[1];
            repeat (6) @(negedge mclk);
            `CHK("statusWriteBlocked", i[0] & ~i[1], swBlk)
        end
        $display("test write_guard done");
        results();
    end

    // The run needs about 2400 cycles; far beyond that counts as a hang.
    initial begin
        repeat (40000) @(negedge mclk);
        error_cnt++;
        results();
    end
endmodule : serial_flash_spi_port_tb
